// *** rtl/cea_consts.svh ***
// constants for the effective-address unit
`ifndef CEA_CONSTS_SVH
`define CEA_CONSTS_SVH
`define CEA_ADDR_W 16
`define CEA_DATA_W 8
`define CEA_PAGE0_HI 8'h00
`define CEA_MODE_W 5
`endif

// *** rtl/cea_pkg.sv ***
// types for the effective-address unit
`default_nettype none
`include "cea_consts.svh"
package cea_pkg;
  typedef enum logic [4:0] {
    M_INH = 5'h00, M_IMM = 5'h01, M_DIR_S = 5'h02, M_DIR_L = 5'h03,
    M_IDX_0 = 5'h04, M_IDX_S = 5'h05, M_IDX_L = 5'h06, M_IND_S = 5'h07,
    M_IND_L = 5'h08, M_IIX_S = 5'h09, M_IIX_L = 5'h0a, M_REL_D = 5'h0b,
    M_REL_I = 5'h0c, M_BIT_D = 5'h0d, M_BIT_I = 5'h0e, M_BTJ_D = 5'h0f,
    M_BTJ_I = 5'h10
  } cea_mode_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_OPB = 3'b001, S_OPB2 = 3'b010, S_PTR = 3'b011,
    S_PTR2 = 3'b100, S_JOFF = 3'b101, S_DONE = 3'b110
  } cea_state_e;
  typedef struct packed {
    cea_mode_e mode;
    logic use_y;
    logic rmw;
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] y;
  } cea_req_s;
  typedef struct packed {
    logic [15:0] ea;
    logic [7:0] imm;
    logic [7:0] rel;
    logic [15:0] next_pc;
    logic is_imm;
    logic is_rel;
    logic err;
  } cea_res_s;
endpackage
`default_nettype wire

// *** rtl/cea_unit.sv ***
// operand fetch and effective-address generation
`timescale 1ns/1ns
`default_nettype none
`include "cea_consts.svh"
module cea_unit (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // request from the sequencer; pc points just past the opcode
  input wire logic i_start,
  input wire cea_pkg::cea_req_s i_req,
  // memory read port, data valid the cycle after o_rd
  output logic o_rd,
  output logic [`CEA_ADDR_W-1:0] o_addr,
  input wire logic [`CEA_DATA_W-1:0] i_rdata,
  // result
  output logic o_busy,
  output logic o_done,
  output cea_pkg::cea_res_s o_res
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  function automatic logic is_long(input cea_pkg::cea_mode_e m);
    is_long = (m == cea_pkg::M_DIR_L) || (m == cea_pkg::M_IDX_L) ||
              (m == cea_pkg::M_IND_L) || (m == cea_pkg::M_IIX_L);
  endfunction

  function automatic logic is_ptr(input cea_pkg::cea_mode_e m);
    is_ptr = (m == cea_pkg::M_IND_S) || (m == cea_pkg::M_IND_L) ||
             (m == cea_pkg::M_IIX_S) || (m == cea_pkg::M_IIX_L) ||
             (m == cea_pkg::M_REL_I) || (m == cea_pkg::M_BIT_I) ||
             (m == cea_pkg::M_BTJ_I);
  endfunction

  function automatic logic is_idx(input cea_pkg::cea_mode_e m);
    is_idx = (m == cea_pkg::M_IDX_0) || (m == cea_pkg::M_IDX_S) ||
             (m == cea_pkg::M_IDX_L) || (m == cea_pkg::M_IIX_S) ||
             (m == cea_pkg::M_IIX_L);
  endfunction

  function automatic logic is_word_ptr(input cea_pkg::cea_mode_e m);
    is_word_ptr = (m == cea_pkg::M_IND_L) || (m == cea_pkg::M_IIX_L);
  endfunction

  function automatic logic is_bitjump(input cea_pkg::cea_mode_e m);
    is_bitjump = (m == cea_pkg::M_BTJ_D) || (m == cea_pkg::M_BTJ_I);
  endfunction

  // page-zero addresses never carry into the high byte
  function automatic logic [15:0] page0(input logic [7:0] b);
    page0 = {`CEA_PAGE0_HI, b};
  endfunction

  function automatic logic [15:0] sext(input logic [7:0] b);
    sext = {{8{b[7]}}, b};
  endfunction

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  cea_pkg::cea_state_e state;
  cea_pkg::cea_state_e next_state;
  cea_pkg::cea_req_s req;
  cea_pkg::cea_req_s next_req;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [15:0] word;
  logic [15:0] next_word;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rd;
  logic next_rd;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic done;
  logic next_done;
  logic busy;
  logic next_busy;
  cea_pkg::cea_res_s res;
  cea_pkg::cea_res_s next_res;
  logic [7:0] idx;
  logic [15:0] sum;
  logic [15:0] rel_tgt;

  assign idx = req.use_y ? req.y : req.x;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // every fetch state waits out the strobe cycle: data lands one
  // cycle after o_rd, so each byte costs two clocks
  always_comb begin
    next_state = state;
    next_req = req;
    next_pc = pc;
    next_word = word;
    next_ptr = ptr;
    next_rd = 1'b0;
    next_addr = addr;
    next_done = 1'b0;
    next_busy = busy;
    next_res = res;
    sum = 16'h0000;
    rel_tgt = 16'h0000;
    case (state)
      cea_pkg::S_IDLE: begin
        if (i_start) begin
          next_req = i_req;
          next_pc = i_req.pc;
          next_word = 16'h0000;
          next_res = '0;
          next_busy = 1'b1;
          if (i_req.rmw && is_long(i_req.mode)) begin
            next_res.err = 1'b1;
            next_state = cea_pkg::S_DONE;
          end else if (i_req.mode == cea_pkg::M_INH ||
                       (i_req.mode == cea_pkg::M_IDX_0 && !i_req.use_y)) begin
            next_state = cea_pkg::S_DONE;
          end else begin
            // second index register costs one prefix-free byte fetch
            next_rd = 1'b1;
            next_addr = i_req.pc;
            next_pc = i_req.pc + 16'h0001;
            next_state = cea_pkg::S_OPB;
          end
        end
      end
      cea_pkg::S_OPB: begin
        if (!rd) begin
          next_word = {word[7:0], i_rdata};
          if (is_long(req.mode) && !is_ptr(req.mode)) begin
            next_rd = 1'b1;
            next_addr = pc;
            next_pc = pc + 16'h0001;
            next_state = cea_pkg::S_OPB2;
          end else if (is_ptr(req.mode)) begin
            next_ptr = i_rdata;
            next_rd = 1'b1;
            next_addr = page0(i_rdata);
            next_state = cea_pkg::S_PTR;
          end else begin
            next_state = cea_pkg::S_DONE;
          end
        end
      end
      cea_pkg::S_OPB2: begin
        if (!rd) begin
          next_word = {word[7:0], i_rdata};
          next_state = cea_pkg::S_DONE;
        end
      end
      cea_pkg::S_PTR: begin
        if (!rd) begin
          next_word = {8'h00, i_rdata};
          if (is_word_ptr(req.mode)) begin
            next_word = {i_rdata, 8'h00};
            next_rd = 1'b1;
            // low byte of a word pointer wraps inside page zero
            next_addr = page0(ptr + 8'h01);
            next_state = cea_pkg::S_PTR2;
          end else begin
            next_state = cea_pkg::S_DONE;
          end
        end
      end
      cea_pkg::S_PTR2: begin
        if (!rd) begin
          next_word = {word[15:8], i_rdata};
          next_state = cea_pkg::S_DONE;
        end
      end
      cea_pkg::S_JOFF: begin
        if (!rd) begin
          next_word = {8'h00, i_rdata};
          next_state = cea_pkg::S_DONE;
        end
      end
      cea_pkg::S_DONE: begin
        next_res.next_pc = pc;
        // bit-test-jump: offset byte follows the address byte
        if (is_bitjump(req.mode) && !res.is_rel && !res.err) begin
          next_res.ea = word;
          next_res.is_rel = 1'b1;
          next_rd = 1'b1;
          next_addr = pc;
          next_pc = pc + 16'h0001;
          next_state = cea_pkg::S_JOFF;
        end else begin
          if (res.is_rel) begin
            // jump offset from the bit-test path
            rel_tgt = pc + sext(word[7:0]);
            next_res.rel = word[7:0];
            next_res.next_pc = rel_tgt;
          end else begin
            case (req.mode)
              cea_pkg::M_IMM: begin
                next_res.imm = word[7:0];
                next_res.is_imm = 1'b1;
              end
              cea_pkg::M_IDX_0: next_res.ea = page0(idx);
              cea_pkg::M_IDX_S, cea_pkg::M_IDX_L, cea_pkg::M_IIX_S,
              cea_pkg::M_IIX_L: begin
                sum = word + {8'h00, idx};
                next_res.ea = sum;
              end
              cea_pkg::M_REL_D, cea_pkg::M_REL_I: begin
                rel_tgt = pc + sext(word[7:0]);
                next_res.rel = word[7:0];
                next_res.is_rel = 1'b1;
                next_res.next_pc = rel_tgt;
              end
              cea_pkg::M_INH: next_res.ea = 16'h0000;
              default: next_res.ea = word;
            endcase
          end
          next_done = 1'b1;
          next_busy = 1'b0;
          next_state = cea_pkg::S_IDLE;
        end
      end
      default: next_state = cea_pkg::S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cea_pkg::S_IDLE;
      req <= '0;
      pc <= 16'h0000;
      word <= 16'h0000;
      ptr <= 8'h00;
      rd <= 1'b0;
      addr <= 16'h0000;
      done <= 1'b0;
      busy <= 1'b0;
      res <= '0;
    end else begin
      state <= next_state;
      req <= next_req;
      pc <= next_pc;
      word <= next_word;
      ptr <= next_ptr;
      rd <= next_rd;
      addr <= next_addr;
      done <= next_done;
      busy <= next_busy;
      res <= next_res;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign o_rd = rd;
  assign o_addr = addr;
  assign o_done = done;
  assign o_busy = busy;
  assign o_res = res;
endmodule // cea_unit
`default_nettype wire

// *** sim/cea_mem_model.sv ***
// memory model on the unit's read port
`timescale 1ns/1ns
`default_nettype none
module cea_mem_model (
  // read port
  input wire logic i_mclk,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  output logic [7:0] o_rdata
);
  initial o_rdata = 8'h00;
  // idle bus shows inverted data so a stale byte never passes
  always @(posedge i_mclk) o_rdata <= i_rd ? i_addr[7:0] ^ i_addr[15:8] ^ 8'h5a : ~o_rdata;
endmodule // cea_mem_model
`default_nettype wire

// *** sim/cea_unit_sva.sv ***
// checker for the effective-address unit
`timescale 1ns/1ns
`default_nettype none
module cea_unit_sva (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // request and memory
  input wire logic i_start,
  input wire cea_pkg::cea_req_s i_req,
  input wire logic o_rd,
  input wire logic [15:0] o_addr,
  input wire logic [7:0] i_rdata,
  // result
  input wire logic o_busy,
  input wire logic o_done,
  input wire cea_pkg::cea_res_s o_res
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  wire go = i_start && !o_busy;
  wire [4:0] md = i_req.mode;
  sequence s_pc_rd;
    o_rd && o_addr == $past(i_req.pc);
  endsequence
  sequence s_done_byte;
    ##3 o_done && o_res.ea == {8'h00, $past(i_rdata, 2)};
  endsequence
  AST_INH: assert property (go && md == cea_pkg::M_INH |=> !o_rd ##1 o_done && !o_rd)
    else $error("inherent op fetched a byte");
  AST_IMM: assert property (go && md == cea_pkg::M_IMM |=> s_pc_rd
    ##3 o_done && o_res.imm == $past(i_rdata, 2)) else $error("immediate byte wrong");
  AST_DIRL: assert property (go && md == cea_pkg::M_DIR_L && !i_req.rmw |=> s_pc_rd
    ##2 o_rd && o_addr == $past(i_req.pc, 3) + 16'h0001
    ##3 o_done && o_res.ea == {$past(i_rdata, 4), $past(i_rdata, 2)})
    else $error("long address word wrong");
  AST_DIRS: assert property (go && md == cea_pkg::M_DIR_S |=> s_pc_rd ##0 s_done_byte)
    else $error("short direct left page zero");
  AST_IDX0: assert property (go && md == cea_pkg::M_IDX_0 && !i_req.use_y |=>
    !o_rd ##1 o_done && o_res.ea == {8'h00, $past(i_req.x, 2)}) else $error("no-offset index");
  AST_IDXS: assert property (go && md == cea_pkg::M_IDX_S && !i_req.use_y |=>
    ##3 o_done && o_res.ea == {8'h00, $past(i_rdata, 2)} + {8'h00, $past(i_req.x, 4)})
    else $error("short indexed sum wrong");
  AST_INDS: assert property (go && md == cea_pkg::M_IND_S |=> s_pc_rd
    ##2 o_rd && o_addr == {8'h00, $past(i_rdata)}) else $error("pointer read off page zero");
  AST_REL: assert property (go && md == cea_pkg::M_REL_D |=> ##3 o_done
    && o_res.is_rel && o_res.rel == $past(i_rdata, 2)
    && o_res.next_pc == $past(i_req.pc, 4) + 16'h0001 + {{8{o_res.rel[7]}}, o_res.rel})
    else $error("relative target wrong");
  AST_RMWL: assert property (go && i_req.rmw && md inside {cea_pkg::M_DIR_L,
    cea_pkg::M_IDX_L, cea_pkg::M_IND_L, cea_pkg::M_IIX_L} |=> !o_rd ##1 o_done && o_res.err)
    else $error("long rmw not refused");
  AST_BUSY: assert property (go |=> o_busy)
    else $error("busy not raised after start");
  AST_DONE_FREE: assert property (o_done |-> !o_busy)
    else $error("busy still high with done");
endmodule // cea_unit_sva
bind cea_unit cea_unit_sva i_cea_unit_sva (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_start(i_start), .i_req(i_req), .o_rd(o_rd), .o_addr(o_addr), .i_rdata(i_rdata),
  .o_busy(o_busy), .o_done(o_done), .o_res(o_res));
`default_nettype wire

// *** sim/cea_unit_tb_top.sv ***
// self-checking bench for the effective-address unit
`timescale 1ns/1ns
`default_nettype none
module cea_unit_tb_top;
  typedef struct packed {logic [1:0] c; logic [15:0] ea; logic [15:0] np; logic er;} cea_ex_s;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_start = 1'b0;
  cea_pkg::cea_req_s i_req = '0;
  cea_pkg::cea_req_s r;
  cea_pkg::cea_res_s o_res;
  logic o_rd, o_busy, o_done;
  logic [15:0] o_addr;
  logic [7:0] i_rdata;
  int bad_count = 0, comparisons = 0, seed = 12;
  cea_ex_s q[$];
  cea_ex_s e;
  always #25 i_mclk = ~i_mclk;
  cea_unit i_cea_unit (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_start(i_start), .i_req(i_req),
    .o_rd(o_rd), .o_addr(o_addr), .i_rdata(i_rdata), .o_busy(o_busy), .o_done(o_done),
    .o_res(o_res));
  cea_mem_model i_cea_mem_model (.i_mclk(i_mclk), .i_rd(o_rd), .i_addr(o_addr),
    .o_rdata(i_rdata));
  function automatic logic [7:0] m(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [15:0] s(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] x);
    comparisons++;
    if (seen !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, seen);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic cea_ex_s ex(input cea_pkg::cea_req_s r);
    logic [15:0] p, w, a;
    logic [7:0] i, b, t;
    p = r.pc;
    i = r.use_y ? r.y : r.x;
    b = m(p);
    t = m({8'h00, b});
    w = {b, m(p + 16'h1)};
    // long pointer low byte wraps inside page zero
    a = {t, m({8'h00, b + 8'h01})};
    ex = '{2'd1, {8'h00, b}, p + 16'h1, 1'b0};
    case (r.mode)
      cea_pkg::M_INH: ex = '{2'd0, 16'h0, p, 1'b0};
      cea_pkg::M_IMM: ex.c = 2'd2;
      cea_pkg::M_DIR_L: ex = '{2'd1, w, p + 16'h2, 1'b0};
      cea_pkg::M_IDX_0: ex = '{2'd1, {8'h00, i}, r.use_y ? p + 16'h1 : p, 1'b0};
      cea_pkg::M_IDX_S: ex.ea = {8'h00, b} + {8'h00, i};
      cea_pkg::M_IDX_L: ex = '{2'd1, w + {8'h00, i}, p + 16'h2, 1'b0};
      cea_pkg::M_IND_S, cea_pkg::M_BIT_I: ex.ea = {8'h00, t};
      cea_pkg::M_IND_L: ex.ea = a;
      cea_pkg::M_IIX_S: ex.ea = {8'h00, t} + {8'h00, i};
      cea_pkg::M_IIX_L: ex.ea = a + {8'h00, i};
      cea_pkg::M_REL_D: ex = '{2'd0, 16'h0, p + 16'h1 + s(b), 1'b0};
      cea_pkg::M_REL_I: ex = '{2'd0, 16'h0, p + 16'h1 + s(t), 1'b0};
      cea_pkg::M_BTJ_D: ex.np = p + 16'h2 + s(m(p + 16'h1));
      cea_pkg::M_BTJ_I: ex = '{2'd1, {8'h00, t}, p + 16'h2 + s(m(p + 16'h1)), 1'b0};
      default: ;
    endcase
    if (r.rmw && r.mode inside {cea_pkg::M_DIR_L, cea_pkg::M_IDX_L, cea_pkg::M_IND_L,
        cea_pkg::M_IIX_L}) ex = '{2'd0, 16'h0, 16'h0, 1'b1};
  endfunction
  task automatic run(input cea_pkg::cea_req_s v);
    int n;
    n = 0;
    q.push_back(ex(v));
    i_start <= 1'b1;
    i_req <= v;
    @(posedge i_mclk);
    i_start <= 1'b0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_done !== 1'b1 && n < 30);
    if (n == 30) chk("done", 16'h0, 16'h1);
    @(posedge i_mclk);
  endtask
  always @(posedge i_mclk) begin
    if (o_done === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk("err", {15'h0, o_res.err}, {15'h0, e.er});
      if (!e.er) chk("next_pc", o_res.next_pc, e.np);
      if (e.c == 2'd1) chk("ea", o_res.ea, e.ea);
      if (e.c == 2'd2) chk("imm", {8'h00, o_res.imm}, e.ea);
      chk("is_imm", {15'h0, o_res.is_imm}, {15'h0, e.c == 2'd2});
    end
  end
  initial begin
    #1000000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    for (int k = 0; k < 17; k++) begin
      for (int j = 0; j < 6; j++) begin
        r.mode = cea_pkg::cea_mode_e'(k[4:0]);
        r.pc = j == 0 ? 16'h00a5 : 16'($random(seed));
        {r.x, r.y, r.use_y, r.rmw} = 18'($random(seed));
        // first pass puts offset and index at ff for the 1fe reach
        if (j == 0) {r.x, r.y} = 16'hffff;
        run(r);
      end
      $display("test mode %0d done", k);
    end
    stop_test;
  end
endmodule // cea_unit_tb_top
`default_nettype wire
